/* include/sdpci_pkg.sv */
`default_nettype none

package sdpci_pkg;

  // ---------------------------------------------------------------------
  // pin widths and organisation
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int DQ_W = 16;
  localparam int BYTE_W = 8;
  localparam int MASK_W = 2;
  localparam int COL_W_X16 = 9;
  localparam int COL_W_X8 = 10;
  localparam int PRE_SCOPE_BIT = 10;

  // byte-wide variant: one mask pin (the lower one) covers all lines
  localparam logic BYTE_WIDE = 1'h0;

  // ---------------------------------------------------------------------
  // storage kept behind the pins
  // ---------------------------------------------------------------------
  localparam int MEM_COL_W = 6;
  localparam int MEM_IDX_W = BANK_W + MEM_COL_W;
  localparam int MEM_DEPTH = 1 << MEM_IDX_W;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [MASK_W-1:0] MASK_RST = 2'h3;
  localparam logic [MASK_W-1:0] OE_RST = 2'h0;
  localparam logic [DQ_W-1:0] DQ_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;

  // ---------------------------------------------------------------------
  // commands, coded as {row strobe, column strobe, write enable}
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } sdpci_cmd_type;

  // ---------------------------------------------------------------------
  // states while clock enable is low
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    LP_NONE = 2'h0,
    LP_POWER_DOWN = 2'h1,
    LP_CLOCK_SUSPEND = 2'h2,
    LP_SELF_REFRESH = 2'h3
  } sdpci_lp_type;

endpackage

`default_nettype wire

/* src/sdpci_sync2.sv */
`default_nettype none

module sdpci_sync2 (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_i,     // synchronous reset, active high
  input wire logic async_i,   // asynchronous level
  output logic sync_o         // level on clk_sys_i
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

`default_nettype wire

/* src/sdpci_top.sv */
`default_nettype none

module sdpci_top (
  input wire logic clk_sys_i,                           // master clock
  input wire logic rst_i,                               // sync reset
  input wire logic cke_i,                               // clock enable
  input wire logic cs_n_i,                              // select, low
  input wire logic ras_n_i,                             // row strobe
  input wire logic cas_n_i,                             // column strobe
  input wire logic we_n_i,                              // write enable
  input wire logic [sdpci_pkg::ADDR_W-1:0] address_bus_bits_i, // address
  input wire logic [sdpci_pkg::BANK_W-1:0] bank_select_pins_i, // bank
  input wire logic lower_byte_mask_i,                   // mask, byte 0
  input wire logic upper_byte_mask_i,                   // mask, byte 1
  input wire logic [sdpci_pkg::DQ_W-1:0] data_lines_i,  // data in
  output logic [sdpci_pkg::DQ_W-1:0] data_lines_o,      // data out
  output logic [sdpci_pkg::MASK_W-1:0] data_lines_oe_o, // per-byte enable
  output sdpci_pkg::sdpci_lp_type lp_state_o,           // low-power state
  output logic [sdpci_pkg::ADDR_W-1:0] mode_o,          // mode op-code
  output logic [sdpci_pkg::NUM_BANKS-1:0] bank_open_o   // open rows
);

  import sdpci_pkg::*;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [MASK_W-1:0] eff_mask(
    input logic [MASK_W-1:0] m
  );
    eff_mask = BYTE_WIDE ? {MASK_W{m[0]}} : m;
  endfunction

  function automatic logic [MEM_IDX_W-1:0] mem_index(
    input logic [BANK_W-1:0] ba,
    input logic [ADDR_W-1:0] a
  );
    logic [COL_W_X8-1:0] col;
    col = BYTE_WIDE ? a[COL_W_X8-1:0]
                    : {1'h0, a[COL_W_X16-1:0]};
    mem_index = {ba, col[MEM_COL_W-1:0]};
  endfunction

  // ---------------------------------------------------------------------
  // clock enable is asynchronous: resynchronise it
  // ---------------------------------------------------------------------
  logic cke_s;

  sdpci_sync2 u_cke_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(cke_i),
    .sync_o(cke_s)
  );

  // ---------------------------------------------------------------------
  // pin capture on every rising edge
  // ---------------------------------------------------------------------
  logic cs_n_q;
  logic cs_n_d;
  logic [2:0] cmd_raw_q;
  logic [2:0] cmd_raw_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [BANK_W-1:0] ba_q;
  logic [BANK_W-1:0] ba_d;
  logic [MASK_W-1:0] mask_q;
  logic [MASK_W-1:0] mask_d;
  logic [DQ_W-1:0] dq_in_q;
  logic [DQ_W-1:0] dq_in_d;

  always_comb begin
    cs_n_d = cs_n_i;
    cmd_raw_d = {ras_n_i, cas_n_i, we_n_i};
    addr_d = address_bus_bits_i;
    ba_d = bank_select_pins_i;
    mask_d = {upper_byte_mask_i, lower_byte_mask_i};
    dq_in_d = data_lines_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cs_n_q <= 1'h1;
      cmd_raw_q <= CMD_NOP;
      addr_q <= MODE_RST;
      ba_q <= '0;
      mask_q <= MASK_RST;
      dq_in_q <= DQ_RST;
    end else begin
      cs_n_q <= cs_n_d;
      cmd_raw_q <= cmd_raw_d;
      addr_q <= addr_d;
      ba_q <= ba_d;
      mask_q <= mask_d;
      dq_in_q <= dq_in_d;
    end
  end

  // ---------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------
  sdpci_cmd_type cmd;
  logic [NUM_BANKS-1:0] bank_open_q;
  logic [NUM_BANKS-1:0] bank_open_d;
  logic edge_ok;
  logic issue;
  logic ap;
  logic [MEM_IDX_W-1:0] idx;

  assign cmd = sdpci_cmd_type'(cmd_raw_q);
  assign edge_ok = cke_s;
  assign issue = edge_ok && !cs_n_q;
  assign ap = addr_q[PRE_SCOPE_BIT];
  assign idx = mem_index(ba_q, addr_q);

  // ---------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------
  logic [DQ_W-1:0] mem [MEM_DEPTH];
  logic [MASK_W-1:0] wr_mask;
  logic wr_en;

  assign wr_mask = eff_mask(mask_q);
  assign wr_en = issue && (cmd == CMD_WRITE) && bank_open_q[ba_q];

  always_ff @(posedge clk_sys_i) begin
    if (wr_en) begin
      for (int b = 0; b < MASK_W; b++) begin
        if (!wr_mask[b]) begin
          mem[idx][b*BYTE_W +: BYTE_W] <=
            dq_in_q[b*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // bank, mode, read pipeline and low-power state
  // ---------------------------------------------------------------------
  logic [ADDR_W-1:0] row_q [NUM_BANKS];
  logic [ADDR_W-1:0] row_d [NUM_BANKS];
  logic [ADDR_W-1:0] mode_q;
  logic [ADDR_W-1:0] mode_d;
  logic [MASK_W-1:0] mask_p1_q;
  logic [MASK_W-1:0] mask_p1_d;
  logic rd_vld_p1_q;
  logic rd_vld_p1_d;
  logic [DQ_W-1:0] rd_data_p1_q;
  logic [DQ_W-1:0] rd_data_p1_d;
  logic [DQ_W-1:0] dq_out_q;
  logic [DQ_W-1:0] dq_out_d;
  logic [MASK_W-1:0] dq_oe_q;
  logic [MASK_W-1:0] dq_oe_d;
  sdpci_lp_type lp_q;
  sdpci_lp_type lp_d;

  always_comb begin
    bank_open_d = bank_open_q;
    row_d = row_q;
    mode_d = mode_q;
    mask_p1_d = mask_p1_q;
    rd_vld_p1_d = rd_vld_p1_q;
    rd_data_p1_d = rd_data_p1_q;
    dq_out_d = dq_out_q;
    dq_oe_d = dq_oe_q;
    lp_d = lp_q;
    // pipelines freeze while edges are invalid
    if (edge_ok) begin
      mask_p1_d = eff_mask(mask_q);
      rd_vld_p1_d = 1'h0;
      dq_out_d = rd_data_p1_q;
      dq_oe_d = rd_vld_p1_q ? ~mask_p1_q : OE_RST;
    end
    if (issue) begin
      unique case (cmd)
        CMD_ACT: begin
          bank_open_d[ba_q] = 1'h1;
          row_d[ba_q] = addr_q;
        end
        CMD_READ: begin
          if (bank_open_q[ba_q]) begin
            rd_vld_p1_d = 1'h1;
            rd_data_p1_d = mem[idx];
            if (ap) begin
              bank_open_d[ba_q] = 1'h0;
            end
          end
        end
        CMD_WRITE: begin
          if (bank_open_q[ba_q] && ap) begin
            bank_open_d[ba_q] = 1'h0;
          end
        end
        CMD_PRE: begin
          if (ap) begin
            bank_open_d = '0;
          end else begin
            bank_open_d[ba_q] = 1'h0;
          end
        end
        CMD_MRS: begin
          // ignored unless every bank is idle
          if (bank_open_q == '0) begin
            mode_d = addr_q;
          end
        end
        CMD_NOP, CMD_BST, CMD_REF: begin
        end
      endcase
    end
    if (cke_s) begin
      lp_d = LP_NONE;
    end else if (lp_q == LP_NONE) begin
      if (!cs_n_q && cmd == CMD_REF) begin
        lp_d = LP_SELF_REFRESH;
      end else if ((bank_open_q != '0) || rd_vld_p1_q) begin
        lp_d = LP_CLOCK_SUSPEND;
      end else begin
        lp_d = LP_POWER_DOWN;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bank_open_q <= '0;
      for (int i = 0; i < NUM_BANKS; i++) begin
        row_q[i] <= MODE_RST;
      end
      mode_q <= MODE_RST;
      mask_p1_q <= MASK_RST;
      rd_vld_p1_q <= 1'h0;
      rd_data_p1_q <= DQ_RST;
      dq_out_q <= DQ_RST;
      dq_oe_q <= OE_RST;
      lp_q <= LP_NONE;
    end else begin
      bank_open_q <= bank_open_d;
      row_q <= row_d;
      mode_q <= mode_d;
      mask_p1_q <= mask_p1_d;
      rd_vld_p1_q <= rd_vld_p1_d;
      rd_data_p1_q <= rd_data_p1_d;
      dq_out_q <= dq_out_d;
      dq_oe_q <= dq_oe_d;
      lp_q <= lp_d;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign data_lines_o = dq_out_q;
  assign data_lines_oe_o = dq_oe_q;
  assign lp_state_o = lp_q;
  assign mode_o = mode_q;
  assign bank_open_o = bank_open_q;

endmodule

`default_nettype wire

/* dv/sdpci_top_monitor.sv */
`default_nettype none
// ----------------------------------------
// pin checker for the sdram pin block
// ----------------------------------------
module sdpci_top_monitor (
  input wire logic clk_sys_i, // clock
  input wire logic rst_i, // reset
  input wire logic cke_i, // clock enable
  input wire logic cs_n_i, // select
  input wire logic ras_n_i, // row strobe
  input wire logic cas_n_i, // column strobe
  input wire logic we_n_i, // write enable
  input wire logic [sdpci_pkg::ADDR_W-1:0] address_bus_bits_i, // address
  input wire logic [sdpci_pkg::BANK_W-1:0] bank_select_pins_i, // bank
  input wire logic lower_byte_mask_i, // mask 0
  input wire logic upper_byte_mask_i, // mask 1
  input wire logic [sdpci_pkg::MASK_W-1:0] data_lines_oe_o, // enable
  input wire sdpci_pkg::sdpci_lp_type lp_state_o, // low power
  input wire logic [sdpci_pkg::ADDR_W-1:0] mode_o, // mode
  input wire logic [sdpci_pkg::NUM_BANKS-1:0] bank_open_o // open rows
);
  timeunit 1ns;
  timeprecision 1ns;
  import sdpci_pkg::*;
  logic [2:0] cmd, run_q, run_d;
  logic ck, sel;
  assign cmd = {ras_n_i, cas_n_i, we_n_i};
  assign ck = run_q == 3'h7 && cke_i;
  assign sel = ck && !cs_n_i;
  // count of steady clock-enable cycles
  always_comb begin
    run_d = cke_i ? run_q + {2'h0, run_q != 3'h7} : 3'h0;
  end
  always_ff @(posedge clk_sys_i) begin
    run_q <= rst_i ? 3'h0 : run_d;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_oe_after_read: assert property (
    ck && |data_lines_oe_o |-> $past(!cs_n_i && cmd == CMD_READ, 3))
    else $error("drive enable without a read");
  a_oe_mask_delay: assert property (ck |-> (
    data_lines_oe_o & {$past(upper_byte_mask_i, 3),
    $past(lower_byte_mask_i, 3)}) == 2'h0) else $error("masked byte driven");
  a_act_opens_row: assert property (
    sel && cmd == CMD_ACT |-> ##2 bank_open_o[$past(bank_select_pins_i, 2)])
    else $error("activate did not open bank");
  a_pre_all_banks: assert property (
    sel && cmd == CMD_PRE && address_bus_bits_i[PRE_SCOPE_BIT]
    |-> ##2 bank_open_o == 4'h0) else $error("banks still open");
  a_pre_one_bank: assert property (
    sel && cmd == CMD_PRE && !address_bus_bits_i[PRE_SCOPE_BIT]
    |-> ##2 !bank_open_o[$past(bank_select_pins_i, 2)])
    else $error("bank still open");
  a_mode_load_op: assert property (
    sel && cmd == CMD_MRS && bank_open_o == 4'h0
    && !$past(!cs_n_i && cmd == CMD_ACT)
    |-> ##2 mode_o == $past(address_bus_bits_i, 2)) else $error("mode wrong");
  a_desel_holds: assert property (
    cs_n_i |-> ##2 $stable(mode_o)) else $error("mode moved unselected");
  a_lp_exit: assert property (
    ck |-> lp_state_o == LP_NONE) else $error("low power with clock on");
  a_lp_entry: assert property (
    !cke_i [*5] |-> lp_state_o != LP_NONE) else $error("no low power state");
  c_read: cover property (|data_lines_oe_o);
  c_self_refresh: cover property (lp_state_o == LP_SELF_REFRESH);
  c_suspend: cover property (lp_state_o == LP_CLOCK_SUSPEND);
endmodule

bind sdpci_top sdpci_top_monitor i_sdpci_top_monitor (.clk_sys_i, .rst_i,
  .cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .address_bus_bits_i,
  .bank_select_pins_i, .lower_byte_mask_i, .upper_byte_mask_i,
  .data_lines_oe_o, .lp_state_o, .mode_o, .bank_open_o);
`default_nettype wire

/* dv/sdpci_ctrl_model.sv */
`default_nettype none
// ----------------------------------------
// memory controller driving the pins
// ----------------------------------------
module sdpci_ctrl_model (
  input wire logic clk_sys_i, // clock
  output logic cs_n_o, // select
  output logic ras_n_o, // row strobe
  output logic cas_n_o, // column strobe
  output logic we_n_o, // write enable
  output logic [12:0] addr_o, // address
  output logic [1:0] bank_o, // bank
  output logic lmask_o, // mask 0
  output logic umask_o, // mask 1
  input wire logic [15:0] dev_dq_i, // device data
  input wire logic [1:0] dev_oe_i, // device enable
  output logic [15:0] bus_o // data wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  import sdpci_pkg::*;
  logic [15:0] wdata_q, last_q;
  logic drive_q = 1'h0;
  initial begin
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
    {addr_o, bank_o, umask_o, lmask_o} = 17'h00003;
  end
  task issue(input logic s, input sdpci_cmd_type c, input logic [1:0] b,
    input logic [12:0] a, input logic [15:0] d, input logic [1:0] m);
    @(posedge clk_sys_i);
    cs_n_o <= !s;
    {ras_n_o, cas_n_o, we_n_o} <= c;
    bank_o <= b;
    addr_o <= a;
    wdata_q <= d;
    drive_q <= c == CMD_WRITE;
    {umask_o, lmask_o} <= m;
  endtask
  // released bytes show the inverse of the last level
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      bus_o[i*8+:8] = dev_oe_i[i] ? dev_dq_i[i*8+:8] :
        drive_q ? wdata_q[i*8+:8] : ~last_q[i*8+:8];
    end
  end
  always_ff @(posedge clk_sys_i) begin
    last_q <= bus_o;
  end
endmodule
`default_nettype wire

/* dv/sdpci_top_tb.sv */
`default_nettype none
module sdpci_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sdpci_pkg::*;
  logic clk_sys_i = 1'h0;
  logic rst_i = 1'h1;
  logic cke_i = 1'h1;
  logic cs_n_i, ras_n_i, cas_n_i, we_n_i;
  logic lower_byte_mask_i, upper_byte_mask_i;
  logic [ADDR_W-1:0] address_bus_bits_i, mode_o;
  logic [BANK_W-1:0] bank_select_pins_i;
  logic [MASK_W-1:0] data_lines_oe_o;
  logic [DQ_W-1:0] data_lines_i, data_lines_o;
  logic [NUM_BANKS-1:0] bank_open_o;
  sdpci_lp_type lp_state_o;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  sdpci_top i_sdpci_top (.clk_sys_i, .rst_i, .cke_i, .cs_n_i, .ras_n_i,
    .cas_n_i, .we_n_i, .address_bus_bits_i, .bank_select_pins_i,
    .lower_byte_mask_i, .upper_byte_mask_i, .data_lines_i, .data_lines_o,
    .data_lines_oe_o, .lp_state_o, .mode_o, .bank_open_o);
  sdpci_ctrl_model i_sdpci_ctrl_model (.clk_sys_i, .cs_n_o(cs_n_i),
    .ras_n_o(ras_n_i), .cas_n_o(cas_n_i), .we_n_o(we_n_i),
    .addr_o(address_bus_bits_i), .bank_o(bank_select_pins_i),
    .lmask_o(lower_byte_mask_i), .umask_o(upper_byte_mask_i),
    .dev_dq_i(data_lines_o), .dev_oe_i(data_lines_oe_o), .bus_o(data_lines_i));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task conclude;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      conclude();
    end
  end
  task chk(input string n, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task go(input sdpci_cmd_type c, input logic [1:0] b, input logic [12:0] a,
    input logic [15:0] d, input logic [1:0] m);
    i_sdpci_ctrl_model.issue(1'h1, c, b, a, d, m);
  endtask
  task look(input int n);
    repeat (n) go(CMD_NOP, 2'h0, 13'h0000, 16'h0000, 2'h0);
    @(negedge clk_sys_i);
  endtask
  task rd(input logic [1:0] b, input logic [12:0] a, input logic [1:0] m, e,
    input logic [15:0] d);
    go(CMD_READ, b, a, 16'h0000, m);
    // opposite mask on the next edge must not reach this read
    go(CMD_NOP, 2'h0, 13'h0000, 16'h0000, ~m);
    look(2);
    chk("read enable", {14'h0000, e}, {14'h0000, data_lines_oe_o});
    chk("read data", d, data_lines_i & {{8{e[1]}}, {8{e[0]}}});
  endtask
  task chk_open(input logic [3:0] o);
    look(2);
    chk("open banks", {12'h000, o}, {12'h000, bank_open_o});
  endtask
  task lp_try(input sdpci_cmd_type c, input sdpci_lp_type e,
    input logic [3:0] o);
    go(c, 2'h0, 13'h0000, 16'h0000, 2'h0);
    cke_i <= 1'h0;
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("low power", {14'h0000, e}, {14'h0000, lp_state_o});
    go(CMD_ACT, 2'h2, 13'h0001, 16'h0000, 2'h0);
    go(CMD_NOP, 2'h0, 13'h0000, 16'h0000, 2'h0);
    cke_i <= 1'h1;
    look(8);
    chk("awake", 16'h0000, {14'h0000, lp_state_o});
    chk("open banks", {12'h000, o}, {12'h000, bank_open_o});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_mode;
    go(CMD_MRS, 2'h0, 13'h0123, 16'h0000, 2'h0);
    look(2);
    chk("mode", 16'h0123, {3'h0, mode_o});
    i_sdpci_ctrl_model.issue(1'h0, CMD_MRS, 2'h0, 13'h1F0F, 16'h0000, 2'h0);
    look(2);
    chk("mode unselected", 16'h0123, {3'h0, mode_o});
  endtask
  task t_rw;
    go(CMD_ACT, 2'h2, 13'h1ABC, 16'h0000, 2'h0);
    chk_open(4'h4);
    go(CMD_WRITE, 2'h2, 13'h0005, 16'hA55A, 2'h0);
    go(CMD_WRITE, 2'h2, 13'h0006, 16'hFFFF, 2'h0);
    go(CMD_WRITE, 2'h2, 13'h0006, 16'h1234, 2'h2);
    rd(2'h2, 13'h0005, 2'h0, 2'h3, 16'hA55A);
    rd(2'h2, 13'h0006, 2'h2, 2'h1, 16'h0034);
    rd(2'h2, 13'h0006, 2'h0, 2'h3, 16'hFF34);
    rd(2'h2, 13'h0005, 2'h1, 2'h2, 16'hA500);
    go(CMD_PRE, 2'h2, 13'h0000, 16'h0000, 2'h0);
    chk_open(4'h0);
    rd(2'h2, 13'h0005, 2'h0, 2'h0, 16'h0000);
  endtask
  task t_banks;
    go(CMD_ACT, 2'h0, 13'h0010, 16'h0000, 2'h0);
    go(CMD_ACT, 2'h3, 13'h0020, 16'h0000, 2'h0);
    chk_open(4'h9);
    go(CMD_PRE, 2'h3, 13'h0000, 16'h0000, 2'h0);
    chk_open(4'h1);
    go(CMD_ACT, 2'h1, 13'h0030, 16'h0000, 2'h0);
    go(CMD_PRE, 2'h2, 13'h0400, 16'h0000, 2'h0);
    chk_open(4'h0);
    go(CMD_ACT, 2'h1, 13'h0030, 16'h0000, 2'h0);
    go(CMD_NOP, 2'h0, 13'h0000, 16'h0000, 2'h0);
    go(CMD_WRITE, 2'h1, 13'h0403, 16'h5A5A, 2'h0);
    chk_open(4'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("reset", 16'h0000, {mode_o, bank_open_o[2:0]});
    chk("reset out", 16'h0000,
      {8'h00, bank_open_o, data_lines_oe_o, lp_state_o});
    @(posedge clk_sys_i);
    rst_i <= 1'h0;
    look(3);
    t_mode();
    t_rw();
    t_banks();
    lp_try(CMD_NOP, LP_POWER_DOWN, 4'h0);
    lp_try(CMD_REF, LP_SELF_REFRESH, 4'h0);
    go(CMD_ACT, 2'h1, 13'h0030, 16'h0000, 2'h0);
    lp_try(CMD_NOP, LP_CLOCK_SUSPEND, 4'h2);
    conclude();
  end
endmodule
`default_nettype wire
